// *** verilog/tpcf_pkg.sv ***
// Package for the trigger position capture fill block.
// Assumes one system clock; sample strobes arrive synchronous to it.
package tpcf_pkg;

	// ------------------------------------------------------------
	// Storage settings and rates
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TPCF_STORE_ALL,
		TPCF_STORE_NONE,
		TPCF_STORE_TRANS,
		TPCF_STORE_COND,
		TPCF_STORE_STARTSTOP
	} tpcf_store_t;

	typedef enum logic [1:0] {
		TPCF_HR_125PS,
		TPCF_HR_250PS,
		TPCF_HR_500PS,
		TPCF_HR_1NS
	} tpcf_hrrate_t;

	// High-resolution trigger position ceilings, percent
	localparam logic [6:0] TPCF_HR_MAX_125 = 7'h3A;
	localparam logic [6:0] TPCF_HR_MAX_250 = 7'h4F;
	localparam logic [6:0] TPCF_HR_MAX_500 = 7'h59;
	localparam logic [6:0] TPCF_HR_MAX_1NS = 7'h5E;
	localparam logic [6:0] TPCF_PCT_FULL   = 7'h64;

	// Divider ratios from the fastest high-resolution rate
	localparam logic [2:0] TPCF_DIV_125 = 3'h1;
	localparam logic [2:0] TPCF_DIV_250 = 3'h2;
	localparam logic [2:0] TPCF_DIV_500 = 3'h4;
	localparam logic [2:0] TPCF_DIV_1NS = 3'h0;

	// Reset values
	localparam logic [6:0] TPCF_RST_POS = 7'h32;

	// Sample with its store qualifiers
	typedef struct packed {
		logic [15:0] data;
		logic        store_one;
		logic        qual;
	} tpcf_smp_t;

	// Word written to acquisition memory
	typedef struct packed {
		logic [15:0] data;
		logic        post;
	} tpcf_wr_t;

endpackage : tpcf_pkg

// *** verilog/tpcf_top.sv ***
// Trigger position capture fill: places samples around a trigger in main memory,
// with forced prefill, system trigger override and high-resolution memory control.
// Assumes all inputs synchronous to CLK_SYS and memory write port with ready.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Pre and post trigger shares of the depth follow the trigger position percentage.
// - After trigger, post samples are stored until the post share fills, then acquisition stops.
// - A trigger before the pre share is met is taken at once; only the post share of post data is then stored.
// - With forced prefill, the trigger machine waits until the prefill amount is stored.
// - Forced prefill is unavailable under None or Start/Stop storage.
// - A system trigger overrides forced prefill and starts the trigger machine at once.
// - Prefill samples already stored are kept on a system trigger.
// - After a system trigger in prefill, only post samples are stored until the post share fills.
// - The high-resolution rate can be slowed from the fastest rate.
// - The high-resolution trigger position is set apart from the main one.
// - At 125 ps the high-resolution position is limited to 0 to 58 percent.
// - At 250 ps the high-resolution position is limited to 0 to 79 percent.
// - At 500 ps the high-resolution position is limited to 0 to 89 percent.
// - At 1 ns the high-resolution position is limited to 0 to 94 percent.
// - High-resolution capture runs before the run starts, so it needs no prefill.
// - Under None storage only store-one-sample samples are written.
module tpcf_top #(
	parameter int AW = 12
) (
	input  wire logic               CLK_SYS,
	input  wire logic               ARST_N,
	input  wire logic               RUN,
	input  wire logic [AW:0]        DEPTH,
	input  wire logic [6:0]         TRIG_POS,
	input  wire tpcf_pkg::tpcf_store_t STORE_MODE,
	input  wire logic               FORCE_PREFILL,
	input  wire logic [AW:0]        PREFILL_AMT,
	input  wire logic               TRIG_EVT,
	input  wire logic               SYS_TRIG,
	input  wire logic               SMP_VALID,
	input  wire tpcf_pkg::tpcf_smp_t SMP,
	input  wire tpcf_pkg::tpcf_hrrate_t HR_RATE,
	input  wire logic [6:0]         HR_POS,
	input  wire logic               MEM_READY,
	output logic                    MEM_VALID,
	output tpcf_pkg::tpcf_wr_t      MEM_WORD,
	output logic [AW-1:0]           MEM_ADDR,
	output logic                    TRIGGERED,
	output logic                    DONE,
	output logic                    PREFILL_AVAIL,
	output logic                    HR_TICK,
	output logic [6:0]              HR_POS_EFF,
	output logic [AW-1:0]           TRIG_ADDR
);
	import tpcf_pkg::*;

	// Refuse address widths the counters and casts cannot serve
	if (AW < 2 || AW > 24) begin : g_aw_chk
		$error("AW out of range");
	end

	typedef enum logic [1:0] {S_IDLE, S_PREFILL, S_PRE, S_POST} tpcf_state_t;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_reg, rst_n_reg;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// Shares and qualification
	// ------------------------------------------------------------
	logic [AW+7:0] pre_prod;
	logic [AW:0]   pre_share, post_share;
	logic          prefill_ok, store_en, accept;
	tpcf_state_t   state_reg;
	logic [AW:0]   pre_cnt_reg, post_cnt_reg;
	logic [AW-1:0] wptr_reg;
	logic          buf_in_ready;

	// Percent split of the depth
	assign pre_prod   = (AW+8)'(DEPTH) * (AW+8)'(TRIG_POS);
	assign pre_share  = (AW+1)'(pre_prod / (AW+8)'(TPCF_PCT_FULL));
	assign post_share = DEPTH - pre_share;
	// No prefill when nothing is stored by default
	assign prefill_ok = FORCE_PREFILL && (STORE_MODE != TPCF_STORE_NONE)
		&& (STORE_MODE != TPCF_STORE_STARTSTOP);
	// None stores only the explicitly picked sample
	always_comb begin
		case (STORE_MODE)
			TPCF_STORE_NONE: store_en = SMP.store_one;
			TPCF_STORE_ALL:  store_en = 1'b1;
			default:         store_en = SMP.qual;
		endcase
	end
	assign accept = SMP_VALID && buf_in_ready && (state_reg != S_IDLE) && store_en;

	// ------------------------------------------------------------
	// Fill state machine
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE: if (RUN) begin
					state_reg <= prefill_ok ? S_PREFILL : S_PRE;
				end
				S_PREFILL: if (SYS_TRIG) begin
					state_reg <= S_POST;
				end else if (pre_cnt_reg >= PREFILL_AMT) begin
					state_reg <= S_PRE;
				end
				S_PRE: if (TRIG_EVT || SYS_TRIG) begin
					state_reg <= S_POST;
				end
				S_POST: if (post_cnt_reg >= post_share) begin
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Trigger and completion flags
	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			TRIGGERED <= 1'b0;
			DONE      <= 1'b0;
			TRIG_ADDR <= '0;
		end else if (state_reg == S_IDLE && RUN) begin
			TRIGGERED <= 1'b0;
			DONE      <= 1'b0;
		end else if (state_reg != S_POST && state_reg != S_IDLE && (TRIG_EVT || SYS_TRIG)
			&& !(state_reg == S_PREFILL && !SYS_TRIG)) begin
			TRIGGERED <= 1'b1;
			TRIG_ADDR <= wptr_reg;
		end else if (state_reg == S_POST && post_cnt_reg >= post_share) begin
			DONE <= 1'b1;
		end
	end

	// Counters and circular write pointer
	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pre_cnt_reg  <= '0;
			post_cnt_reg <= '0;
			wptr_reg     <= '0;
		end else if (state_reg == S_IDLE && RUN) begin
			pre_cnt_reg  <= '0;
			post_cnt_reg <= '0;
			wptr_reg     <= '0;
		end else if (accept && state_reg != S_POST) begin
			// Wrap inside the pre share; oldest samples are lost
			if (pre_share != '0 && wptr_reg >= AW'(pre_share - 1'b1)) begin
				wptr_reg <= '0;
			end else begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pre_cnt_reg < DEPTH) begin
				pre_cnt_reg <= pre_cnt_reg + 1'b1;
			end
		end else if (accept && post_cnt_reg < post_share) begin
			// Pointer stays at the next pre write slot; post words address by count
			post_cnt_reg <= post_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Two-entry buffer toward memory
	// ------------------------------------------------------------
	tpcf_wr_t    ent_reg [2];
	logic [AW-1:0] ea_reg [2];
	logic [1:0]  cnt_reg;
	logic        rd_reg;
	logic        push, pop;
	logic [AW-1:0] wr_addr;
	assign buf_in_ready = (cnt_reg != 2'h2);
	// Post words land behind the pre share so retained pre samples survive
	assign wr_addr = (state_reg == S_POST) ? AW'(pre_share + post_cnt_reg) : wptr_reg;
	assign push = accept && !(state_reg == S_POST && post_cnt_reg >= post_share);
	assign pop  = MEM_VALID && MEM_READY;

	// Post samples beyond the post share are not written in post stage
	always_ff @(posedge CLK_SYS) begin
		if (push) begin
			// Write slot is read slot plus fill level, pop or not
			ent_reg[rd_reg ^ cnt_reg[0]] <=
				'{data: SMP.data, post: (state_reg == S_POST)};
			ea_reg[rd_reg ^ cnt_reg[0]] <= wr_addr;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cnt_reg <= 2'h0;
			rd_reg  <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
			if (pop) begin
				rd_reg <= ~rd_reg;
			end
		end
	end

	// Registered memory port; holds until taken
	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			MEM_VALID <= 1'b0;
			MEM_WORD  <= '0;
			MEM_ADDR  <= '0;
		end else if (!MEM_VALID || MEM_READY) begin
			MEM_VALID <= (cnt_reg - {1'b0, pop}) != 2'h0;
			MEM_WORD  <= ent_reg[rd_reg ^ pop];
			MEM_ADDR  <= ea_reg[rd_reg ^ pop];
		end
	end

	// ------------------------------------------------------------
	// High-resolution memory control
	// ------------------------------------------------------------
	logic [2:0] hr_div, hr_cnt_reg;
	logic [6:0] hr_max;
	always_comb begin
		case (HR_RATE)
			TPCF_HR_125PS: begin hr_div = TPCF_DIV_125; hr_max = TPCF_HR_MAX_125; end
			TPCF_HR_250PS: begin hr_div = TPCF_DIV_250; hr_max = TPCF_HR_MAX_250; end
			TPCF_HR_500PS: begin hr_div = TPCF_DIV_500; hr_max = TPCF_HR_MAX_500; end
			default:       begin hr_div = TPCF_DIV_1NS; hr_max = TPCF_HR_MAX_1NS; end
		endcase
	end

	// Free running from reset, so filled before any run
	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			hr_cnt_reg <= 3'h0;
			HR_TICK    <= 1'b0;
			HR_POS_EFF <= TPCF_RST_POS;
			PREFILL_AVAIL <= 1'b0;
		end else begin
			hr_cnt_reg <= (hr_cnt_reg + 3'h1 == hr_div) ? 3'h0 : hr_cnt_reg + 3'h1;
			HR_TICK    <= (hr_cnt_reg == 3'h0);
			HR_POS_EFF <= (HR_POS > hr_max) ? hr_max : HR_POS;
			PREFILL_AVAIL <= prefill_ok;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_post_stop;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(state_reg == S_POST && post_cnt_reg >= post_share) |=> state_reg == S_IDLE;
	endproperty
	a_post_stop: assert property (p_post_stop) else $error("post share not ended");

	property p_early;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(state_reg == S_PRE && TRIG_EVT) |=> (state_reg == S_POST && TRIGGERED);
	endproperty
	a_early: assert property (p_early) else $error("early trigger lost");

	property p_hold;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(state_reg == S_PREFILL && !SYS_TRIG && pre_cnt_reg < PREFILL_AMT)
		|=> state_reg == S_PREFILL && !TRIGGERED;
	endproperty
	a_hold: assert property (p_hold) else $error("prefill hold broken");

	property p_nopf;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(STORE_MODE == TPCF_STORE_NONE) |=> !PREFILL_AVAIL;
	endproperty
	a_nopf: assert property (p_nopf) else $error("prefill offered under None");

	sequence s_pf_sys;
		state_reg == S_PREFILL && SYS_TRIG;
	endsequence
	property p_sys;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		s_pf_sys |=> state_reg == S_POST && pre_cnt_reg >= $past(pre_cnt_reg);
	endproperty
	a_sys: assert property (p_sys) else $error("system trigger not taken");

	property p_hrmax;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(HR_RATE == TPCF_HR_125PS) [*2] |-> HR_POS_EFF <= 7'h3A;
	endproperty
	a_hrmax: assert property (p_hrmax) else $error("hr position over 58");

	property p_hr1ns;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(HR_RATE == TPCF_HR_1NS) [*2] |-> HR_POS_EFF <= 7'h5E;
	endproperty
	a_hr1ns: assert property (p_hr1ns) else $error("hr position over 94");

	property p_none;
		@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(push && STORE_MODE == TPCF_STORE_NONE) |-> SMP.store_one;
	endproperty
	a_none: assert property (p_none) else $error("unselected sample stored");

endmodule : tpcf_top
`default_nettype wire

// *** testbench/tpcf_mem_model.sv ***
// Memory-side partner: a write sink that can stall.
// Assumes the capture block's registered valid/ready write port.
`timescale 1ns/10ps
`default_nettype none
module tpcf_mem_model #(
	parameter int AW = 12
) (
	input  wire logic               clk,
	input  wire logic               clr,
	input  wire logic               stall,
	input  wire logic               mem_valid,
	input  wire tpcf_pkg::tpcf_wr_t mem_word,
	input  wire logic [AW-1:0]      mem_addr,
	output logic                    mem_ready,
	output int                      n_pre,
	output int                      n_post,
	output int                      max_pre,
	output int                      n_err
);
	import tpcf_pkg::*;
	logic     held;
	tpcf_wr_t last;
	// Ready drops on alternate cycles under stall
	always @(negedge clk) mem_ready <= !stall || !mem_ready;
	// A stalled word must stand unchanged; counts restart on each run
	always @(posedge clk) begin
		held <= mem_valid && !mem_ready;
		last <= mem_word;
		if (clr) begin
			n_pre <= 0;
			n_post <= 0;
			max_pre <= 0;
			n_err <= 0;
		end else begin
			if (held && mem_valid && mem_word !== last) n_err <= n_err + 1;
			if (mem_valid && mem_ready && mem_word.post) begin
				n_post <= n_post + 1;
			end else if (mem_valid && mem_ready) begin
				n_pre <= n_pre + 1;
				max_pre <= (int'(mem_addr) > max_pre) ? int'(mem_addr) : max_pre;
			end
		end
	end
endmodule // tpcf_mem_model
`default_nettype wire

// *** testbench/test_trigger_position_capture_fill.sv ***
// Self-checking bench for the capture fill block.
// Assumes the memory partner model and inputs driven at falling edges.
`timescale 1ns/10ps
`default_nettype none
module test_trigger_position_capture_fill;
	import tpcf_pkg::*;
	logic clk, arst_n, run, fpre, tev, strg, sv, stall;
	logic [12:0] depth, pamt;
	logic [6:0] tpos, hpos, hpe;
	tpcf_store_t smode;
	tpcf_hrrate_t hrr;
	tpcf_smp_t smp;
	tpcf_wr_t mw;
	logic [11:0] ma, ta;
	logic mv, rdy, trg, done, pav, hrt;
	int n_pre, n_post, max_pre, n_err, n_one, k, d, p;
	int mismatches = 0;
	int num_checks = 0;
	logic [31:0] rnd = 32'h0001_7F30;
	tpcf_top i_tpcf_top (.CLK_SYS(clk), .ARST_N(arst_n), .RUN(run), .DEPTH(depth),
		.TRIG_POS(tpos), .STORE_MODE(smode), .FORCE_PREFILL(fpre), .PREFILL_AMT(pamt),
		.TRIG_EVT(tev), .SYS_TRIG(strg), .SMP_VALID(sv), .SMP(smp), .HR_RATE(hrr),
		.HR_POS(hpos), .MEM_READY(rdy), .MEM_VALID(mv), .MEM_WORD(mw), .MEM_ADDR(ma),
		.TRIGGERED(trg), .DONE(done), .PREFILL_AVAIL(pav), .HR_TICK(hrt),
		.HR_POS_EFF(hpe), .TRIG_ADDR(ta));
	tpcf_mem_model i_tpcf_mem_model (.clk(clk), .clr(run), .stall(stall), .mem_valid(mv),
		.mem_word(mw), .mem_addr(ma), .mem_ready(rdy), .n_pre(n_pre), .n_post(n_post),
		.max_pre(max_pre), .n_err(n_err));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Expected clamp: ceiling per high-resolution rate
	function automatic logic [6:0] clamp(int r, logic [6:0] v);
		logic [6:0] c [4] = '{TPCF_HR_MAX_125, TPCF_HR_MAX_250, TPCF_HR_MAX_500,
			TPCF_HR_MAX_1NS};
		return (v > c[r]) ? c[r] : v;
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	// Spaced samples so the two-word buffer never overruns
	task automatic feed(int n);
		repeat (n) begin
			rnd = xs(rnd);
			stall = rnd[20];
			n_one += rnd[16];
			smp = '{rnd[15:0], rnd[16], 1'b1};
			sv = 1'b1;
			cyc(1);
			sv = 1'b0;
			cyc(3);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	task automatic start(int dd, int pp);
		depth = 13'(dd);
		tpos = 7'(pp);
		pulse(run);
		n_one = 0;
	endtask
	// Feed until the post share is full, bounded
	task automatic finish_run(int dd, int pp);
		k = 0;
		while (done !== 1'b1 && k < 300) begin
			feed(1);
			k++;
		end
		if (k == 300) begin
			mismatches++;
			print_verdict();
		end
		cyc(4);
		k = n_post;
		check(n_post, dd - dd * pp / 100);
		feed(2);
		check(n_post, k);
		check(n_err, 0);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{arst_n, run, fpre, tev, strg, sv, stall} = '0;
		{depth, pamt, tpos, hpos, smp} = '0;
		smode = TPCF_STORE_ALL;
		hrr = TPCF_HR_125PS;
		cyc(16);
		check(hpe, TPCF_RST_POS);
		check(trg, 0);
		arst_n = 1'b1;
		cyc(3);
		for (int r = 0; r < 4; r++) begin
			rnd = xs(rnd);
			hrr = tpcf_hrrate_t'(r);
			hpos = (r == 0) ? 7'h64 : 7'(rnd % 101);
			tpos = rnd[13:7];
			cyc(4);
			check(hpe, clamp(r, hpos));
			k = 0;
			repeat (64) begin
				cyc(1);
				k += hrt;
			end
			check(k, 64 >> r);
		end
		fpre = 1'b1;
		for (int m = 0; m < 5; m++) begin
			smode = tpcf_store_t'(m);
			cyc(3);
			check(pav, m != 1 && m != 4);
		end
		smode = TPCF_STORE_ALL;
		fpre = 1'b0;
		cyc(3);
		check(pav, 0);
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			d = 10 + rnd[4:0];
			p = 10 + rnd[12:8] * 2;
			start(d, p);
			feed(d + 5);
			check(trg, 0);
			pulse(tev);
			check(trg, 1);
			check(n_pre, d + 5);
			check(max_pre, d * p / 100 - 1);
			check(ta, (d + 5) % (d * p / 100));
			finish_run(d, p);
		end
		start(20, 50);
		feed(2);
		pulse(tev);
		check(trg, 1);
		finish_run(20, 50);
		fpre = 1'b1;
		pamt = 13'h0008;
		start(20, 40);
		feed(3);
		pulse(tev);
		check(trg, 0);
		pulse(strg);
		check(trg, 1);
		check(n_pre, 3);
		finish_run(20, 40);
		start(20, 40);
		feed(8);
		pulse(tev);
		check(trg, 1);
		finish_run(20, 40);
		fpre = 1'b0;
		smode = TPCF_STORE_NONE;
		start(16, 50);
		feed(12);
		cyc(4);
		check(n_pre, n_one);
		print_verdict();
	end
endmodule // test_trigger_position_capture_fill
`default_nettype wire
